/* src/upw_inverter.sv */
// Modified-unipolar full-bridge PWM with trip, sigma-delta sensing,
// modulator clock generation and demodulator sync.
// Assumes an Avalon-MM master on SYS_CLK; SD_CLK_IN and SD_DATA are async.
`timescale 1ns/10ps
`include "upw_params.svh"

module upw_inverter
	import upw_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic IRQ,
	input wire logic [`UPW_ADC_W-1:0] ADC_SAMPLE,
	input wire logic ADC_VALID,
	input wire logic SD_CLK_IN,
	input wire logic [1:0] SD_DATA,
	output logic MOD_CLK_OUT,
	output logic SYNC_OUT,
	output logic LEG_A_UPPER_SWITCH,
	output logic LEG_A_LOWER_SWITCH,
	output logic LEG_B_UPPER_SWITCH,
	output logic LEG_B_LOWER_SWITCH
);

	upw_top_s r;
	upw_top_s n;
	logic sd_edge;
	genvar g;

	// Channels 0,1 are data filters, 2,3 comparator filters on same streams
	upw_sd_if sdi[4] ();

	assign sd_edge = r.ck_s2 & ~r.ck_s3;

	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_filt
			assign sdi[g].strobe = sd_edge;
			assign sdi[g].sbit = r.d_s2[g % 2];
			if (g < 2) begin : gen_data
				assign sdi[g].rst = r.sync;
				assign sdi[g].oversampling_ratio = r.dcfg[7:0];
				assign sdi[g].order = r.dcfg[9:8];
			end else begin : gen_comp
				assign sdi[g].rst = 1'b0;
				assign sdi[g].oversampling_ratio = r.ccfg[7:0];
				assign sdi[g].order = r.ccfg[9:8];
			end
			upw_sinc u_sinc (
				.clk(SYS_CLK),
				.rstn(RSTN),
				.sd(sdi[g])
			);
		end
	endgenerate

	function automatic logic [31:0] merge_be(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	always_comb begin
		logic [3:0] set;
		logic [3:0] clr;
		logic do_wr;
		logic pwm_hi;
		logic tripped;
		logic [1:0] want_a;
		logic [1:0] want_b;
		logic [31:0] rd;
		logic [31:0] wv;
		set = 4'h0;
		clr = 4'h0;
		do_wr = 1'b0;
		pwm_hi = 1'b0;
		tripped = 1'b0;
		want_a = 2'h0;
		want_b = 2'h0;
		rd = 32'h0;
		wv = 32'h0;
		n = r;
		n.sync = 1'b0;

		// Two-stage synchronisers for the returning clock and bitstreams
		n.ck_s1 = SD_CLK_IN;
		n.ck_s2 = r.ck_s1;
		n.ck_s3 = r.ck_s2;
		n.d_s1 = SD_DATA;
		n.d_s2 = r.d_s1;

		// Capture unit in clock mode: half period of mdiv+1 cycles
		if (r.mcnt >= r.mdiv) begin
			n.mcnt = 8'h00;
			n.mclk = ~r.mclk;
		end else begin
			n.mcnt = r.mcnt + 8'h01;
		end

		// Up-down carrier; half-cycle change only at the carrier valley
		case (r.dir)
			UPW_UP: begin
				if (r.cnt >= r.period) begin
					n.dir = UPW_DOWN;
					n.cnt = (r.cnt == 16'h0) ? 16'h0 : r.cnt - 16'h1;
				end else begin
					n.cnt = r.cnt + 16'h1;
				end
			end
			UPW_DOWN: begin
				if (r.cnt == 16'h0) begin
					n.dir = UPW_UP;
					n.cnt = (r.period == 16'h0) ? 16'h0 : 16'h1;
					n.sync = 1'b1;
					if (r.neg != r.ctrl_neg) begin
						n.neg = r.ctrl_neg;
						set[`UPW_ST_ZC] = 1'b1;
					end
				end else begin
					n.cnt = r.cnt - 16'h1;
				end
			end
			default: begin
				n.dir = UPW_UP;
				n.cnt = 16'h0;
			end
		endcase

		// Gate pattern, bit 1 upper, bit 0 lower
		pwm_hi = (r.cnt < r.cmp);
		if (!r.neg) begin
			want_a = pwm_hi ? 2'h2 : 2'h1;
			want_b = 2'h1;
		end else begin
			want_a = pwm_hi ? 2'h1 : 2'h2;
			want_b = 2'h2;
		end

		// Window comparator and sigma-delta comparator trips
		if (ADC_VALID &&
			(ADC_SAMPLE < r.win_lo || ADC_SAMPLE > r.win_hi)) begin
			set[`UPW_ST_WIN] = 1'b1;
		end
		if ((sdi[2].fresh && sdi[2].data > r.cthr) ||
			(sdi[3].fresh && sdi[3].data > r.cthr)) begin
			set[`UPW_ST_SDC] = 1'b1;
		end
		tripped = r.status[`UPW_ST_WIN] | r.status[`UPW_ST_SDC];

		// Dead band: a leg passes through both-off for dband+1 cycles
		if (!r.en || tripped || set[`UPW_ST_WIN] || set[`UPW_ST_SDC]) begin
			n.gate_a = 2'h0;
			n.gate_b = 2'h0;
			n.db_a = r.dband;
			n.db_b = r.dband;
		end else begin
			if (r.gate_a != want_a) begin
				if (r.gate_a != 2'h0) begin
					n.gate_a = 2'h0;
					n.db_a = r.dband;
				end else if (r.db_a == 8'h00) begin
					n.gate_a = want_a;
				end else begin
					n.db_a = r.db_a - 8'h01;
				end
			end
			if (r.gate_b != want_b) begin
				if (r.gate_b != 2'h0) begin
					n.gate_b = 2'h0;
					n.db_b = r.dband;
				end else if (r.db_b == 8'h00) begin
					n.gate_b = want_b;
				end else begin
					n.db_b = r.db_b - 8'h01;
				end
			end
		end

		// Read trigger: wait for both data filters to be valid after sync
		if (r.sync) begin
			n.armed = 1'b1;
		end else if (r.armed && sdi[0].valid && sdi[1].valid) begin
			n.armed = 1'b0;
			n.ch0 = sdi[0].data;
			n.ch1 = sdi[1].data;
			n.il = {1'b0, sdi[0].data} + {1'b0, sdi[1].data};
			set[`UPW_ST_SMP] = 1'b1;
		end

		// Register read mux
		case (AVS_ADDRESS)
			`UPW_OFF_CTRL: rd = {30'h0, r.ctrl_neg, r.en};
			`UPW_OFF_PERIOD: rd = {16'h0, r.period};
			`UPW_OFF_CMP: rd = {16'h0, r.cmp};
			`UPW_OFF_DBAND: rd = {24'h0, r.dband};
			`UPW_OFF_DCFG: rd = {22'h0, r.dcfg};
			`UPW_OFF_CCFG: rd = {22'h0, r.ccfg};
			`UPW_OFF_MDIV: rd = {24'h0, r.mdiv};
			`UPW_OFF_WINLO: rd = {20'h0, r.win_lo};
			`UPW_OFF_WINHI: rd = {20'h0, r.win_hi};
			`UPW_OFF_CTHR: rd = {6'h0, r.cthr};
			`UPW_OFF_STATUS: rd = {28'h0, r.status};
			`UPW_OFF_MASK: rd = {28'h0, r.mask};
			`UPW_OFF_IL: rd = {5'h0, r.il};
			`UPW_OFF_CH0: rd = {6'h0, r.ch0};
			`UPW_OFF_CH1: rd = {6'h0, r.ch1};
			default: rd = 32'h0;
		endcase

		// One wait cycle per access keeps read data a flop output
		if (r.waitreq && (AVS_READ || AVS_WRITE)) begin
			n.waitreq = 1'b0;
			if (AVS_READ) begin
				n.readdata = rd;
			end
		end else begin
			n.waitreq = 1'b1;
		end
		do_wr = AVS_WRITE && !r.waitreq;

		if (do_wr) begin
			wv = merge_be(rd, AVS_WRITEDATA, AVS_BYTEENABLE);
			case (AVS_ADDRESS)
				`UPW_OFF_CTRL: begin
					n.en = wv[`UPW_CTRL_EN];
					n.ctrl_neg = wv[`UPW_CTRL_NEG];
				end
				`UPW_OFF_PERIOD: n.period = wv[15:0];
				`UPW_OFF_CMP: n.cmp = wv[15:0];
				`UPW_OFF_DBAND: n.dband = wv[7:0];
				`UPW_OFF_DCFG: n.dcfg = wv[9:0];
				`UPW_OFF_CCFG: n.ccfg = wv[9:0];
				`UPW_OFF_MDIV: n.mdiv = wv[7:0];
				`UPW_OFF_WINLO: n.win_lo = wv[`UPW_ADC_W-1:0];
				`UPW_OFF_WINHI: n.win_hi = wv[`UPW_ADC_W-1:0];
				`UPW_OFF_CTHR: n.cthr = wv[`UPW_SD_W-1:0];
				`UPW_OFF_STATUS: clr = AVS_WRITEDATA[3:0] &
					{4{AVS_BYTEENABLE[0]}};
				`UPW_OFF_MASK: n.mask = wv[3:0];
				default: n.mask = r.mask;
			endcase
		end

		// A new event wins over a write-one clear in the same cycle
		n.status = (r.status & ~clr) | set;
		n.irq = |(n.status & n.mask);
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			r <= '0;
			r.waitreq <= 1'b1;
			r.period <= `UPW_PERIOD_RST;
			r.cmp <= `UPW_CMP_RST;
			r.dband <= `UPW_DBAND_RST;
			r.dcfg <= `UPW_DCFG_RST;
			r.ccfg <= `UPW_CCFG_RST;
			r.mdiv <= `UPW_MDIV_RST;
			r.win_lo <= `UPW_WINLO_RST;
			r.win_hi <= `UPW_WINHI_RST;
			r.cthr <= `UPW_CTHR_RST;
			r.dir <= UPW_UP;
		end else begin
			r <= n;
		end
	end

	assign AVS_READDATA = r.readdata;
	assign AVS_WAITREQUEST = r.waitreq;
	assign IRQ = r.irq;
	assign MOD_CLK_OUT = r.mclk;
	assign SYNC_OUT = r.sync;
	assign LEG_A_UPPER_SWITCH = r.gate_a[1];
	assign LEG_A_LOWER_SWITCH = r.gate_a[0];
	assign LEG_B_UPPER_SWITCH = r.gate_b[1];
	assign LEG_B_LOWER_SWITCH = r.gate_b[0];

endmodule // upw_inverter

/* src/upw_params.svh */
// Offsets, field positions and reset values of the inverter PWM block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef UPW_PARAMS_SVH
`define UPW_PARAMS_SVH

`define UPW_OFF_CTRL 8'h00
`define UPW_OFF_PERIOD 8'h04
`define UPW_OFF_CMP 8'h08
`define UPW_OFF_DBAND 8'h0C
`define UPW_OFF_DCFG 8'h10
`define UPW_OFF_CCFG 8'h14
`define UPW_OFF_MDIV 8'h18
`define UPW_OFF_WINLO 8'h1C
`define UPW_OFF_WINHI 8'h20
`define UPW_OFF_CTHR 8'h24
`define UPW_OFF_STATUS 8'h28
`define UPW_OFF_MASK 8'h2C
`define UPW_OFF_IL 8'h30
`define UPW_OFF_CH0 8'h34
`define UPW_OFF_CH1 8'h38

`define UPW_CTRL_EN 0
`define UPW_CTRL_NEG 1
`define UPW_ST_WIN 0
`define UPW_ST_SDC 1
`define UPW_ST_SMP 2
`define UPW_ST_ZC 3

`define UPW_SD_W 26
`define UPW_ADC_W 12

`define UPW_PERIOD_RST 16'h03E8
`define UPW_CMP_RST 16'h0000
`define UPW_DBAND_RST 8'h08
`define UPW_DCFG_RST 10'h37F
`define UPW_CCFG_RST 10'h21F
`define UPW_MDIV_RST 8'h03
`define UPW_WINLO_RST 12'h000
`define UPW_WINHI_RST 12'hFFF
`define UPW_CTHR_RST 26'h3FFFFFF
`define UPW_VALID_PERIODS 2'h3

`endif

/* src/upw_pkg.sv */
// Types shared by the inverter PWM block and its sinc filters.
// Assumes upw_params.svh on the include path.
`include "upw_params.svh"

package upw_pkg;

	typedef enum logic [1:0] {
		UPW_UP = 2'b01,
		UPW_DOWN = 2'b10
	} upw_dir_e;

	typedef logic [`UPW_SD_W-1:0] upw_sd_t;

	typedef struct packed {
		upw_sd_t i1;
		upw_sd_t i2;
		upw_sd_t i3;
		upw_sd_t d1;
		upw_sd_t d2;
		upw_sd_t d3;
		upw_sd_t data;
		logic [7:0] cnt;
		logic [1:0] nper;
		logic fresh;
	} upw_sinc_s;

	typedef struct packed {
		logic waitreq;
		logic [31:0] readdata;
		logic en;
		logic ctrl_neg;
		logic neg;
		logic [15:0] period;
		logic [15:0] cmp;
		logic [7:0] dband;
		logic [9:0] dcfg;
		logic [9:0] ccfg;
		logic [7:0] mdiv;
		logic [`UPW_ADC_W-1:0] win_lo;
		logic [`UPW_ADC_W-1:0] win_hi;
		upw_sd_t cthr;
		logic [3:0] status;
		logic [3:0] mask;
		logic irq;
		logic [`UPW_SD_W:0] il;
		upw_sd_t ch0;
		upw_sd_t ch1;
		logic armed;
		logic [15:0] cnt;
		upw_dir_e dir;
		logic sync;
		logic [7:0] mcnt;
		logic mclk;
		logic ck_s1;
		logic ck_s2;
		logic ck_s3;
		logic [1:0] d_s1;
		logic [1:0] d_s2;
		logic [1:0] gate_a;
		logic [1:0] gate_b;
		logic [7:0] db_a;
		logic [7:0] db_b;
	} upw_top_s;

endpackage

/* src/upw_sd_if.sv */
// Link between the PWM top and one sinc filter channel.
// Assumes all signals belong to the system clock domain.
`timescale 1ns/10ps
`include "upw_params.svh"

interface upw_sd_if;
	logic strobe;
	logic sbit;
	logic rst;
	logic [7:0] oversampling_ratio;
	logic [1:0] order;
	logic [`UPW_SD_W-1:0] data;
	logic valid;
	logic fresh;

	modport filt (
		input strobe,
		input sbit,
		input rst,
		input oversampling_ratio,
		input order,
		output data,
		output valid,
		output fresh
	);

	modport ctrl (
		output strobe,
		output sbit,
		output rst,
		output oversampling_ratio,
		output order,
		input data,
		input valid,
		input fresh
	);
endinterface

/* src/upw_sinc.sv */
// One sinc1/2/3 decimation filter for a sigma-delta bitstream.
// Assumes strobe marks one modulator bit, already synchronised.
`timescale 1ns/10ps
`include "upw_params.svh"

module upw_sinc
	import upw_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	upw_sd_if.filt sd
);

	upw_sinc_s r;
	upw_sinc_s n;

	always_comb begin
		upw_sd_t c1;
		upw_sd_t c2;
		upw_sd_t c3;
		upw_sd_t x;
		x = '0;
		c1 = '0;
		c2 = '0;
		c3 = '0;
		n = r;
		n.fresh = 1'b0;
		if (sd.rst) begin
			n = '0;
		end else if (sd.strobe) begin
			// Wrapping integrators are exact as long as the width covers (OVERSAMPLING_RATIO+1)^3
			n.i1 = r.i1 + {{(`UPW_SD_W-1){1'b0}}, sd.sbit};
			n.i2 = r.i2 + r.i1;
			n.i3 = r.i3 + r.i2;
			if (r.cnt >= sd.oversampling_ratio) begin
				n.cnt = 8'h00;
				// Comb chain of depth N runs on the Nth integrator, taken
				// after this bit so the first window holds all oversampling_ratio+1 bits
				case (sd.order)
					2'h1: x = n.i1;
					2'h2: x = n.i2;
					default: x = n.i3;
				endcase
				c1 = x - r.d1;
				n.d1 = x;
				c2 = c1 - r.d2;
				n.d2 = c1;
				c3 = c2 - r.d3;
				n.d3 = c2;
				case (sd.order)
					2'h1: n.data = c1;
					2'h2: n.data = c2;
					default: n.data = c3;
				endcase
				n.fresh = 1'b1;
				if (r.nper != `UPW_VALID_PERIODS) begin
					n.nper = r.nper + 2'h1;
				end
			end else begin
				n.cnt = r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign sd.data = r.data;
	assign sd.valid = (r.nper == `UPW_VALID_PERIODS);
	assign sd.fresh = r.fresh;

endmodule // upw_sinc

/* testbench/upw_inverter_asserts.sv */
// Port-level assertions for the inverter PWM top.
// Assumes one SYS_CLK domain and the asynchronous active-low RSTN.
`timescale 1ns/10ps

module upw_inverter_asserts (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	input wire logic MOD_CLK_OUT,
	input wire logic SYNC_OUT,
	input wire logic LEG_A_UPPER_SWITCH,
	input wire logic LEG_A_LOWER_SWITCH,
	input wire logic LEG_B_UPPER_SWITCH,
	input wire logic LEG_B_LOWER_SWITCH
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);

	property p_a_excl;
		!(LEG_A_UPPER_SWITCH && LEG_A_LOWER_SWITCH);
	endproperty
	a_a_excl: assert property (p_a_excl) else $error("leg A both on");
	property p_b_excl;
		!(LEG_B_UPPER_SWITCH && LEG_B_LOWER_SWITCH);
	endproperty
	a_b_excl: assert property (p_b_excl) else $error("leg B both on");
	// A switch may only turn on after its partner was off a full cycle
	property p_a_gap;
		($rose(LEG_A_LOWER_SWITCH) |-> !$past(LEG_A_UPPER_SWITCH)) and
		($rose(LEG_A_UPPER_SWITCH) |-> !$past(LEG_A_LOWER_SWITCH));
	endproperty
	a_a_gap: assert property (p_a_gap) else $error("leg A no gap");
	property p_b_gap;
		($rose(LEG_B_LOWER_SWITCH) |-> !$past(LEG_B_UPPER_SWITCH)) and
		($rose(LEG_B_UPPER_SWITCH) |-> !$past(LEG_B_LOWER_SWITCH));
	endproperty
	a_b_gap: assert property (p_b_gap) else $error("leg B no gap");
	property p_sync;
		SYNC_OUT |=> !SYNC_OUT;
	endproperty
	a_sync: assert property (p_sync) else $error("sync too wide");
	property p_mclk;
		$rose(MOD_CLK_OUT) |-> ##[1:256] $fell(MOD_CLK_OUT);
	endproperty
	a_mclk: assert property (p_mclk) else $error("mod clock stuck");
	property p_wait;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
	endproperty
	a_wait: assert property (p_wait) else $error("no bus answer");
	property p_one;
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST;
	endproperty
	a_one: assert property (p_one) else $error("answer too long");
endmodule // upw_inverter_asserts

bind upw_inverter upw_inverter_asserts u_chk (.SYS_CLK(SYS_CLK),
	.RSTN(RSTN), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .MOD_CLK_OUT(MOD_CLK_OUT),
	.SYNC_OUT(SYNC_OUT), .LEG_A_UPPER_SWITCH(LEG_A_UPPER_SWITCH),
	.LEG_A_LOWER_SWITCH(LEG_A_LOWER_SWITCH),
	.LEG_B_UPPER_SWITCH(LEG_B_UPPER_SWITCH),
	.LEG_B_LOWER_SWITCH(LEG_B_LOWER_SWITCH));

/* testbench/upw_sdmod.sv */
// Two isolated sigma-delta modulators fed by the device's clock.
// Assumes level selects the bit density of each channel.
`timescale 1ns/10ps

module upw_sdmod (
	input wire logic mclk,
	input wire logic [1:0] level,
	output logic [1:0] bits
);
	initial bits = 2'b00;
	// Launch on the falling edge so bits are settled at the sampling edge
	always @(negedge mclk) begin
		bits <= level;
	end
endmodule // upw_sdmod

/* testbench/tb_upw_inverter.sv */
// Self-checking bench for the inverter PWM block.
// Assumes the modulator model and the clock loop on the link pins.
`timescale 1ns/10ps
`include "upw_params.svh"

module tb_upw_inverter;
	logic clk, rstn, rd_s, wr_s, adc_v;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [11:0] adc;
	logic [1:0] lvl;
	wire logic [1:0] sdd;
	wire logic [31:0] rdw;
	wire logic waitreq, irq, mclk, sync, au, al, bu, bl, sck;
	wire logic [3:0] gates = {au, al, bu, bl};
	int n_errors, cmp_count;
	logic waitreq_last;
	always @(posedge clk)
		waitreq_last <= waitreq;
	int hist [16];
	logic [31:0] rv [12] = '{32'h0, 32'h3E8, 32'h0, 32'h8, 32'h37F,
		32'h21F, 32'h3, 32'h0, 32'hFFF, 32'h3FFFFFF, 32'h0, 32'h0};

	// Loop delay keeps the returning clock out of phase with SYS_CLK
	assign #7 sck = mclk;
	upw_inverter u_dut (.SYS_CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr),
		.AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdw),
		.AVS_WAITREQUEST(waitreq), .IRQ(irq), .ADC_SAMPLE(adc),
		.ADC_VALID(adc_v), .SD_CLK_IN(sck), .SD_DATA(sdd),
		.MOD_CLK_OUT(mclk), .SYNC_OUT(sync), .LEG_A_UPPER_SWITCH(au),
		.LEG_A_LOWER_SWITCH(al), .LEG_B_UPPER_SWITCH(bu),
		.LEG_B_LOWER_SWITCH(bl));
	upw_sdmod u_mod (.mclk(mclk), .level(lvl), .bits(sdd));

	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		addr <= a;
		wdata <= d;
		wr_s <= w;
		rd_s <= !w;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (waitreq !== 1'b0 && i < 50);
		rdata = rdw;
		wr_s <= 0;
		rd_s <= 0;
		@(posedge clk);
		if (i == 50 && rdata !== rdw) begin
			n_errors++;
			end_sim();
		end
		if (i == 50 && waitreq_seen_high(i)) begin
			n_errors++;
			end_sim();
		end
	endtask
	// Timeout only when the answer never came within the bound
	function automatic logic waitreq_seen_high(input int i);
		return (i == 50) && (waitreq_last !== 1'b0);
	endfunction
	task automatic wgate(input logic [3:0] g);
		int i;
		for (i = 0; i < 3000 && gates !== g; i++)
			@(posedge clk);
		if (i == 3000) begin
			n_errors++;
			end_sim();
		end
	endtask
	task automatic wst(input int b);
		int i;
		for (i = 0; i < 500; i++) begin
			acc(0, `UPW_OFF_STATUS, 0);
			if (rdata[b] === 1'b1)
				break;
		end
		if (i == 500) begin
			n_errors++;
			end_sim();
		end
	endtask
	// Histogram of gate states over n cycles; 800 cycles is one carrier period at PERIOD 400
	task automatic watch(input int n);
		foreach (hist[k])
			hist[k] = 0;
		repeat (n) begin
			@(posedge clk);
			hist[gates]++;
		end
	endtask

	initial begin
		{rstn, rd_s, wr_s, adc_v, addr, wdata, adc, lvl} = '0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		for (int k = 0; k < 12; k++) begin
			acc(0, 8'(k * 4), 0);
			chk("reset", rv[k], rdata);
		end
		acc(1, 8'h3C, 32'hFFFFFFFF);
		acc(0, 8'h3C, 0);
		chk("unmapped", 0, rdata);
		acc(1, `UPW_OFF_PERIOD, 32'h190);
		acc(1, `UPW_OFF_CMP, 32'h64);
		acc(1, `UPW_OFF_DBAND, 32'h2);
		acc(1, `UPW_OFF_MASK, 32'h8);
		acc(1, `UPW_OFF_CTRL, 32'h1);
		wgate(4'b1001);
		watch(800);
		chk("pos", 800, 32'(hist[1] + hist[5] + hist[9]));
		chk("pos_db", 6, 32'(hist[1]));
		chk("st1", 1, hist[9] > 0);
		chk("st2", 1, hist[5] > 0);
		acc(1, `UPW_OFF_CTRL, 32'h3);
		wgate(4'b1010);
		acc(0, `UPW_OFF_STATUS, 0);
		chk("zc", 8, rdata & 8);
		chk("irq", 1, irq);
		acc(1, `UPW_OFF_STATUS, 32'h8);
		@(posedge clk);
		chk("irq_clr", 0, irq);
		watch(800);
		chk("neg", 800, 32'(hist[2] + hist[6] + hist[10]));
		chk("neg_db", 6, 32'(hist[2]));
		chk("st3", 1, hist[6] > 0);
		chk("st4", 1, hist[10] > 0);
		acc(1, `UPW_OFF_CTRL, 32'h1);
		wgate(4'b1001);
		acc(1, `UPW_OFF_WINHI, 32'h800);
		adc <= 12'h900;
		adc_v <= 1;
		@(posedge clk);
		adc_v <= 0;
		wgate(4'b0000);
		watch(900);
		chk("trip_hold", 900, 32'(hist[0]));
		acc(0, `UPW_OFF_STATUS, 0);
		chk("win_flag", 1, rdata[0]);
		acc(1, `UPW_OFF_STATUS, 32'h1);
		wgate(4'b1001);
		acc(1, `UPW_OFF_MASK, 32'h4);
		// Second wait gives a sample taken wholly under the new setting
		for (int o = 1; o <= 3; o++) begin
			lvl <= (o == 3) ? 2'b11 : 2'b01;
			acc(1, `UPW_OFF_DCFG, {22'h0, 2'(o), 8'h0F});
			repeat (2) begin
				acc(1, `UPW_OFF_STATUS, 32'h4);
				wst(2);
			end
			chk("irq_smp", 1, irq);
			acc(0, `UPW_OFF_CH0, 0);
			chk("ch0", 16 ** o, rdata);
			acc(0, `UPW_OFF_CH1, 0);
			chk("ch1", (o == 3) ? 4096 : 0, rdata);
			acc(0, `UPW_OFF_IL, 0);
			chk("il", (o == 3) ? 8192 : 16 ** o, rdata);
		end
		acc(1, `UPW_OFF_CTHR, 32'h64);
		wgate(4'b0000);
		acc(0, `UPW_OFF_STATUS, 0);
		chk("sdc_flag", 1, rdata[1]);
		acc(1, `UPW_OFF_CTHR, 32'h3FFFFFF);
		acc(1, `UPW_OFF_STATUS, 32'h2);
		wgate(4'b1001);
		end_sim();
	end
endmodule // tb_upw_inverter
